// File: tb/uff_remote.sv
`timescale 1ns/1ps
`default_nettype none
module uff_remote (
  // clock
  input wire logic sys_clk_i,
  // serial lines
  input wire logic tx_i,
  output logic rx_o
);
  initial rx_o = 1'b1;

  // start, eight data bits lsb first, stop; 16 clocks a bit at divisor 1
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk_i);
      rx_o <= f[i];
      repeat (15) @(posedge sys_clk_i);
    end
    @(posedge sys_clk_i);
    rx_o <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
  endtask

  // samples each data bit at its centre
  task automatic recv(output logic [7:0] d);
    @(negedge tx_i);
    repeat (8) @(posedge sys_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge sys_clk_i);
      d[i] = tx_i;
    end
  endtask
endmodule
`default_nettype wire

// File: tb/uff_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
  num_errors++; $display("ERROR %s expected %h seen %h", n, e, a); end end
module uff_top_test
  import uff_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic cts_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic [7:0] b;
  logic tx_o, rts_n_o, int_o, rx_i;
  int num_errors = 0;
  int comparisons = 0;

  uff_top i_uff_top (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .rx_i(rx_i), .cts_n_i(cts_n_i), .tx_o(tx_o),
    .rts_n_o(rts_n_o), .int_o(int_o));
  uff_remote i_uff_remote (.sys_clk_i(sys_clk_i), .tx_i(tx_o),
    .rx_o(rx_i));

  initial forever #4 sys_clk_i = ~sys_clk_i;

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic chk(input logic [3:0] a, input logic [7:0] e, string n);
    logic [7:0] d;
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    `CHK(n, e, d)
  endtask

  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    num_errors++;
    $display("ERROR watchdog expected done seen hang");
    stop_test();
  end

  initial begin
    repeat (12) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 4; i++) chk(A_XON1 + 4'(i), 8'h00, "flow");
    chk(A_LINE_STAT, 8'h60, "idle status");
    wr(A_LINE_CTL, 8'h03);
    $display("test reset done");
    fork
      i_uff_remote.recv(b);
      begin
        repeat (4) @(posedge sys_clk_i);
        wr(A_DATA, 8'hA5);
        repeat (4) @(posedge sys_clk_i);
        chk(A_LINE_STAT, 8'h20, "shifting");
      end
    join
    `CHK("tx byte", 8'hA5, b)
    repeat (30) @(posedge sys_clk_i);
    chk(A_LINE_STAT, 8'h60, "tx done");
    $display("test transmit done");
    i_uff_remote.send(8'h5A, 1'b1);
    chk(A_LINE_STAT, 8'h61, "rx ready");
    i_uff_remote.send(8'h00, 1'b0);
    chk(A_DATA, 8'h5A, "rx byte");
    chk(A_LINE_STAT, 8'h79, "break tags");
    chk(A_DATA, 8'h00, "break byte");
    chk(A_LINE_STAT, 8'h60, "rx empty");
    $display("test receive done");
    wr(A_XON1, 8'h11);
    wr(A_XON1 + 4'h2, 8'h13);
    wr(A_ENH_FEAT, 8'h01);
    i_uff_remote.send(8'h13, 1'b1);
    chk(A_INT_STAT, 8'h11, "xoff flag");
    `CHK("irq", 1'b0, int_o)
    wr(A_DATA, 8'h3C);
    repeat (200) @(posedge sys_clk_i);
    chk(A_LINE_STAT, 8'h00, "halted");
    fork
      i_uff_remote.recv(b);
      i_uff_remote.send(8'h11, 1'b1);
    join
    `CHK("resumed", 8'h3C, b)
    chk(A_INT_STAT, 8'h01, "xon clear");
    $display("test xoff done");
    wr(A_ENH_FEAT, 8'h40);
    wr(A_INT_STAT, 8'h00);
    wr(A_MODEM_CTL, 8'h02);
    repeat (3) @(posedge sys_clk_i);
    `CHK("rts start", 1'b0, rts_n_o)
    for (int i = 1; i <= 17; i++) begin
      i_uff_remote.send(8'(i), 1'b1);
      if (i == 15) `CHK("rts below", 1'b0, rts_n_o)
      if (i == 16) `CHK("rts off", 1'b1, rts_n_o)
    end
    for (int i = 1; i <= 17; i++) begin
      chk(A_DATA, 8'(i), "stored");
      if (i == 16) `CHK("rts held", 1'b1, rts_n_o)
    end
    repeat (2) @(posedge sys_clk_i);
    `CHK("rts back", 1'b0, rts_n_o)
    $display("test rts done");
    wr(A_EXTRA_FEAT, 8'h08);
    wr(A_INT_EN, 8'h03);
    repeat (2) @(posedge sys_clk_i);
    `CHK("tx irq", 1'b1, int_o)
    chk(A_INT_STAT, 8'h02, "tx level");
    wr(A_INT_EN, 8'h01);
    i_uff_remote.send(8'h42, 1'b1);
    chk(A_INT_STAT, 8'h01, "below trigger");
    repeat (850) @(posedge sys_clk_i);
    chk(A_INT_STAT, 8'h08, "timeout");
    `CHK("tmo irq", 1'b1, int_o)
    wr(A_EXTRA_FEAT, 8'h00);
    chk(A_INT_STAT, 8'h0C, "per char");
    chk(A_DATA, 8'h42, "tmo byte");
    chk(A_INT_STAT, 8'h01, "irq clear");
    $display("test interrupt done");
    wr(A_ENH_FEAT, 8'h90);
    wr(A_INT_EN, 8'h80);
    @(posedge sys_clk_i);
    cts_n_i <= 1'b1;
    chk(A_INT_STAT, 8'h20, "cts event");
    wr(A_DATA, 8'h77);
    repeat (50) @(posedge sys_clk_i);
    chk(A_LINE_STAT, 8'h00, "cts halted");
    fork
      i_uff_remote.recv(b);
      begin
        @(posedge sys_clk_i);
        cts_n_i <= 1'b0;
      end
    join
    `CHK("cts resume", 8'h77, b)
    $display("test cts done");
    wr(A_ENH_FEAT, 8'h04);
    for (int i = 1; i <= 8; i++) i_uff_remote.send(8'(i), 1'b1);
    i_uff_remote.recv(b);
    `CHK("xoff sent", 8'h13, b)
    fork
      i_uff_remote.recv(b);
      for (int i = 1; i <= 8; i++) chk(A_DATA, 8'(i), "drain");
    join
    `CHK("xon sent", 8'h11, b)
    $display("test auto xoff done");
    stop_test();
  end
endmodule
`default_nettype wire

// File: verilog/uff_mem.sv
`timescale 1ns/1ps
`default_nettype none
module uff_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  // clock
  input wire logic sys_clk_i,
  // write side
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // read side
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem [DEPTH];

  // write-through so a word written into an empty fifo is seen at once
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= (we_i && waddr_i == raddr_i) ? wdata_i : mem[raddr_i];
  end
endmodule
`default_nettype wire

// File: verilog/uff_pkg.sv
`default_nettype none
package uff_pkg;
  localparam int FIFO_DEPTH = 32;
  localparam int ADDR_W = 4;
  // register offsets
  localparam logic [3:0] A_DATA = 4'h0;
  localparam logic [3:0] A_INT_EN = 4'h1;
  localparam logic [3:0] A_INT_STAT = 4'h2;
  localparam logic [3:0] A_LINE_CTL = 4'h3;
  localparam logic [3:0] A_MODEM_CTL = 4'h4;
  localparam logic [3:0] A_LINE_STAT = 4'h5;
  localparam logic [3:0] A_ENH_FEAT = 4'h6;
  localparam logic [3:0] A_EXTRA_FEAT = 4'h7;
  localparam logic [3:0] A_XON1 = 4'h8;
  localparam logic [3:0] A_XCHR_MASK = 4'hC;
  localparam logic [3:0] A_DIV_LO = 4'hC;
  localparam logic [3:0] A_DIV_HI = 4'hD;
  // field positions
  localparam int LS_THR_EMPTY = 5;
  localparam int LS_TX_EMPTY = 6;
  localparam int IE_RX = 0;
  localparam int IE_TX = 1;
  localparam int IE_XOFF = 5;
  localparam int IE_RTS = 6;
  localparam int IE_CTS = 7;
  localparam int EF_SW_RX = 0;
  localparam int EF_SW_DOUBLE = 1;
  localparam int EF_SW_TX = 2;
  localparam int EF_ENH = 4;
  localparam int EF_AUTO_RTS = 6;
  localparam int EF_AUTO_CTS = 7;
  localparam int MC_RTS = 1;
  localparam int XF_RX_TRIG_INT = 3;
  localparam int LC_PAR_EN = 3;
  localparam int LC_PAR_EVEN = 4;
  localparam int FC_TX_TRIG = 4;
  localparam int FC_RX_TRIG = 6;
  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h0001;
  // serial timing, in 16x ticks and bits
  localparam int OVERSAMPLE = 16;
  localparam int MID_SAMPLE = 8;
  localparam logic [3:0] OS_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] MID_LAST = 4'(MID_SAMPLE - 1);
  localparam logic [3:0] FRAME_BASE = 4'h7;
  localparam logic [2:0] WL_LAST_BASE = 3'h4;
  localparam logic [7:0] WL_MASK_BASE = 8'hE0;
  localparam int TMO_WORDS = 4;
  localparam int TMO_EXTRA_BITS = 12;
  localparam int FLOW_DELAY_CHARS = 2;
  // fifo levels
  localparam logic [5:0] LVL_0 = 6'h00;
  localparam logic [5:0] LVL_8 = 6'h08;
  localparam logic [5:0] LVL_16 = 6'h10;
  localparam logic [5:0] LVL_24 = 6'h18;
  localparam logic [5:0] LVL_28 = 6'h1C;
  localparam logic [5:0] LVL_32 = 6'h20;

  typedef struct packed {
    logic brk;
    logic frm;
    logic perr;
    logic [7:0] data;
  } uff_rx_entry_t;

  function automatic logic [5:0] uff_trig(input logic [1:0] s);
    case (s)
      2'b00: return LVL_8;
      2'b01: return LVL_16;
      2'b10: return LVL_24;
      default: return LVL_28;
    endcase
  endfunction

  function automatic logic [5:0] uff_trig_above(input logic [1:0] s);
    case (s)
      2'b00: return LVL_16;
      2'b01: return LVL_24;
      2'b10: return LVL_28;
      default: return LVL_32;
    endcase
  endfunction

  function automatic logic [5:0] uff_trig_below(input logic [1:0] s);
    case (s)
      2'b00: return LVL_0;
      2'b01: return LVL_8;
      2'b10: return LVL_16;
      default: return LVL_24;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: verilog/uff_pkg_unused_guard.sv
`default_nettype none
`default_nettype wire

// File: verilog/uff_top.sv
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module uff_top
  import uff_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // serial link
  input wire logic rx_i,
  input wire logic cts_n_i,
  output logic tx_o,
  output logic rts_n_o,
  // interrupt request
  output logic int_o
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam logic [PW-1:0] PTR_ONE = PW'(1);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
    uff_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
    uff_rx_state_t;

  logic [7:0] int_enable, fifo_control, line_control, modem_control;
  logic [7:0] enhanced_feature, extra_feature;
  logic [7:0] flow_chr [4];
  logic [15:0] divisor, div_cnt;
  logic tick;
  logic [PW-1:0] tx_wr_ptr, tx_rd_ptr, rx_wr_ptr, rx_rd_ptr;
  logic [CW-1:0] tx_count, rx_count;
  logic [7:0] tx_head, tx_char;
  uff_rx_entry_t rx_head, rx_new;
  uff_tx_state_t tx_state;
  uff_rx_state_t rx_state;
  logic [3:0] tx_tcnt, rx_tcnt;
  logic [2:0] tx_bit, rx_bit;
  logic [7:0] rx_char;
  logic rx_prev, rx_perr, rx_frm, rx_done;
  logic prev_on1, prev_off1, xoff_flag, flow_evt;
  logic rts_hold, cts_prev, rx_above_q;
  logic [1:0] flow_left;
  logic flow_off, xoff_sent, xdly_run;
  logic [8:0] xdly_cnt;
  logic [9:0] tmo_cnt;

  // decode
  wire enh_en = enhanced_feature[EF_ENH];
  wire wr_data = wr_i && addr_i == A_DATA;
  wire rd_data = rd_i && addr_i == A_DATA;
  wire rd_istat = rd_i && addr_i == A_INT_STAT;
  wire xchr_sel = (addr_i & A_XCHR_MASK) == A_XON1;
  wire [1:0] rx_sel = fifo_control[FC_RX_TRIG+:2];
  wire [1:0] tx_sel = fifo_control[FC_TX_TRIG+:2];
  wire [CW-1:0] rx_trig = CW'(uff_trig(rx_sel));
  wire [CW-1:0] tx_trig = CW'(uff_trig(tx_sel));
  wire [CW-1:0] rts_hi = CW'(uff_trig_above(rx_sel));
  wire [CW-1:0] rts_lo = CW'(uff_trig_below(rx_sel));

  // character geometry from the line control word length
  wire [7:0] wl_mask = ~(WL_MASK_BASE << line_control[1:0]);
  wire [2:0] wl_last = WL_LAST_BASE + {1'b0, line_control[1:0]};
  wire par_en = line_control[LC_PAR_EN];
  wire [3:0] frame_bits = FRAME_BASE + {2'b00, line_control[1:0]}
                          + {3'b000, par_en};
  wire [5:0] tmo_bits = 6'(frame_bits * TMO_WORDS + TMO_EXTRA_BITS);
  wire [9:0] tmo_limit = 10'(tmo_bits * OVERSAMPLE);
  wire [8:0] xdly_limit = 9'(frame_bits * FLOW_DELAY_CHARS * OVERSAMPLE);

  // register writes; enhanced interrupt enables are locked unless the enhanced feature bit is set
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      int_enable <= REG_RESET;
      fifo_control <= REG_RESET;
      line_control <= REG_RESET;
      modem_control <= REG_RESET;
      enhanced_feature <= REG_RESET;
      extra_feature <= REG_RESET;
      divisor <= DIV_RESET;
      for (int i = 0; i < 4; i++) begin
        flow_chr[i] <= REG_RESET;
      end
    end else if (wr_i) begin
      if (xchr_sel) begin
        flow_chr[addr_i[1:0]] <= wdata_i;
      end
      case (addr_i)
        A_INT_EN: int_enable <= enh_en ? wdata_i :
                                {int_enable[7:4], wdata_i[3:0]};
        A_INT_STAT: fifo_control <= wdata_i;
        A_LINE_CTL: line_control <= wdata_i;
        A_MODEM_CTL: modem_control <= wdata_i;
        A_ENH_FEAT: enhanced_feature <= wdata_i;
        A_EXTRA_FEAT: extra_feature <= wdata_i;
        A_DIV_HI: divisor[15:8] <= wdata_i;
        default: ;
      endcase
      if (addr_i == A_DIV_LO) begin
        divisor[7:0] <= wdata_i;
      end
    end
  end

  // 16x sampling tick
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= div_cnt >= divisor - 16'h0001;
      div_cnt <= (div_cnt >= divisor - 16'h0001) ? 16'h0000 :
                 div_cnt + 16'h0001;
    end
  end

  // transmit fifo
  wire cts_halt = enhanced_feature[EF_AUTO_CTS] && cts_n_i;
  wire sw_rx_en = enhanced_feature[EF_SW_RX];
  wire xoff_halt = sw_rx_en && xoff_flag;
  wire tx_idle = tx_state == TX_IDLE;
  wire tx_push = wr_data && tx_count != CNT_FULL;
  wire tx_start_flow = tx_idle && !cts_halt && flow_left != 2'h0;
  wire tx_load = tx_idle && !cts_halt && flow_left == 2'h0 &&
                 !xoff_halt && tx_count != '0;
  wire [PW-1:0] tx_raddr = tx_load ? tx_rd_ptr + PTR_ONE : tx_rd_ptr;
  wire thr_empty = tx_count == '0;
  wire tx_empty = thr_empty && tx_idle;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_wr_ptr <= '0;
      tx_rd_ptr <= '0;
      tx_count <= '0;
    end else begin
      if (tx_push) tx_wr_ptr <= tx_wr_ptr + PTR_ONE;
      if (tx_load) tx_rd_ptr <= tx_rd_ptr + PTR_ONE;
      if (tx_push && !tx_load) tx_count <= tx_count + CNT_ONE;
      else if (!tx_push && tx_load) tx_count <= tx_count - CNT_ONE;
    end
  end

  uff_mem #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_mem (
    .sys_clk_i(sys_clk_i),
    .we_i(tx_push),
    .waddr_i(tx_wr_ptr),
    .wdata_i(wdata_i),
    .raddr_i(tx_raddr),
    .rdata_o(tx_head)
  );

  // transmitter; halts are only looked at between characters
  wire dbl = enhanced_feature[EF_SW_DOUBLE];
  wire [1:0] flow_idx = {flow_off, dbl && flow_left == 2'h1};
  wire tx_par_bit = (^(tx_char & wl_mask)) ^ ~line_control[LC_PAR_EVEN];
  wire tx_bit_end = tick && tx_tcnt == OS_LAST;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_state <= TX_IDLE;
      tx_o <= 1'b1;
      tx_tcnt <= 4'h0;
      tx_bit <= 3'h0;
      tx_char <= 8'h00;
    end else begin
      if (tick) tx_tcnt <= tx_tcnt + 4'h1;
      unique case (tx_state)
        TX_IDLE: if (tx_load || tx_start_flow) begin
          tx_char <= tx_load ? tx_head : flow_chr[flow_idx];
          tx_state <= TX_START;
          tx_o <= 1'b0;
          tx_tcnt <= 4'h0;
          tx_bit <= 3'h0;
        end
        TX_START: if (tx_bit_end) begin
          tx_state <= TX_DATA;
          tx_o <= tx_char[0];
        end
        TX_DATA: if (tx_bit_end) begin
          if (tx_bit == wl_last) begin
            tx_state <= par_en ? TX_PAR : TX_STOP;
            tx_o <= par_en ? tx_par_bit : 1'b1;
          end else begin
            tx_bit <= tx_bit + 3'h1;
            tx_o <= tx_char[tx_bit + 3'h1];
          end
        end
        TX_PAR: if (tx_bit_end) begin
          tx_state <= TX_STOP;
          tx_o <= 1'b1;
        end
        TX_STOP: if (tx_bit_end) tx_state <= TX_IDLE;
      endcase
    end
  end

  // receiver
  wire rx_par_exp = (^(rx_char & wl_mask)) ^ ~line_control[LC_PAR_EVEN];
  wire rx_bit_end = tick && rx_tcnt == OS_LAST;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_state <= RX_IDLE;
      rx_prev <= 1'b1;
      rx_tcnt <= 4'h0;
      rx_bit <= 3'h0;
      rx_char <= 8'h00;
      rx_perr <= 1'b0;
      rx_frm <= 1'b0;
      rx_done <= 1'b0;
    end else begin
      rx_prev <= rx_i;
      rx_done <= 1'b0;
      if (tick) rx_tcnt <= rx_tcnt + 4'h1;
      unique case (rx_state)
        RX_IDLE: if (rx_prev && !rx_i) begin
          rx_state <= RX_START;
          rx_tcnt <= 4'h0;
        end
        RX_START: if (tick && rx_tcnt == MID_LAST) begin
          rx_tcnt <= 4'h0;
          rx_bit <= 3'h0;
          rx_char <= 8'h00;
          rx_perr <= 1'b0;
          rx_state <= rx_i ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_bit_end) begin
          rx_char[rx_bit] <= rx_i;
          rx_bit <= rx_bit + 3'h1;
          if (rx_bit == wl_last) rx_state <= par_en ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (rx_bit_end) begin
          rx_perr <= rx_i != rx_par_exp;
          rx_state <= RX_STOP;
        end
        RX_STOP: if (rx_bit_end) begin
          rx_frm <= !rx_i;
          rx_done <= 1'b1;
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  // flow character matching on the word length bits only
  wire [7:0] rx_m = rx_char & wl_mask;
  wire m_on1 = rx_m == (flow_chr[0] & wl_mask);
  wire m_on2 = rx_m == (flow_chr[1] & wl_mask);
  wire m_off1 = rx_m == (flow_chr[2] & wl_mask);
  wire m_off2 = rx_m == (flow_chr[3] & wl_mask);
  wire xon_hit = rx_done && sw_rx_en && (dbl ? prev_on1 && m_on2 : m_on1);
  wire xoff_hit = rx_done && sw_rx_en &&
                  (dbl ? prev_off1 && m_off2 : m_off1);
  wire flow_match = sw_rx_en &&
                    (m_on1 || m_off1 || (dbl && (m_on2 || m_off2)));

  // receive fifo; accepts until full whatever rts shows
  wire rx_push = rx_done && !flow_match && rx_count != CNT_FULL;
  wire rx_pop = rd_data && rx_count != '0;
  wire [PW-1:0] rx_raddr = rx_pop ? rx_rd_ptr + PTR_ONE : rx_rd_ptr;
  wire rx_ready = rx_count != '0;
  assign rx_new = '{brk: rx_frm && rx_char == 8'h00, frm: rx_frm,
                    perr: rx_perr, data: rx_char};

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_wr_ptr <= '0;
      rx_rd_ptr <= '0;
      rx_count <= '0;
    end else begin
      if (rx_push) rx_wr_ptr <= rx_wr_ptr + PTR_ONE;
      if (rx_pop) rx_rd_ptr <= rx_rd_ptr + PTR_ONE;
      if (rx_push && !rx_pop) rx_count <= rx_count + CNT_ONE;
      else if (!rx_push && rx_pop) rx_count <= rx_count - CNT_ONE;
    end
  end

  uff_mem #(.WIDTH($bits(uff_rx_entry_t)), .DEPTH(DEPTH)) u_rx_mem (
    .sys_clk_i(sys_clk_i),
    .we_i(rx_push),
    .waddr_i(rx_wr_ptr),
    .wdata_i(rx_new),
    .raddr_i(rx_raddr),
    .rdata_o(rx_head)
  );

  // flow control state
  wire auto_rts = enhanced_feature[EF_AUTO_RTS] &&
                  modem_control[MC_RTS];
  wire next_rts_hold = auto_rts &&
    (rx_count >= rts_hi || (rts_hold && rx_count > rts_lo));
  wire rts_rise = next_rts_hold && !rts_hold;
  wire cts_rise = enhanced_feature[EF_AUTO_CTS] && cts_n_i && !cts_prev;
  wire flow_set = (rts_rise && int_enable[IE_RTS]) ||
                  (cts_rise && int_enable[IE_CTS]);
  wire sw_tx_en = enhanced_feature[EF_SW_TX];
  wire rx_above = rx_count >= rx_trig;
  wire xoff_fire = xdly_run && tick && xdly_cnt == xdly_limit;
  wire xon_fire = sw_tx_en && xoff_sent && !xdly_run &&
                  rx_count <= rts_lo;
  wire [1:0] flow_n = dbl ? 2'h2 : 2'h1;
  wire tmo_hit = rx_ready && tmo_cnt == tmo_limit;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rts_hold <= 1'b0;
      rts_n_o <= 1'b1;
      cts_prev <= 1'b0;
      flow_evt <= 1'b0;
      prev_on1 <= 1'b0;
      prev_off1 <= 1'b0;
      xoff_flag <= 1'b0;
    end else begin
      rts_hold <= next_rts_hold;
      rts_n_o <= ~modem_control[MC_RTS] | next_rts_hold;
      cts_prev <= cts_n_i;
      if (flow_set) flow_evt <= 1'b1;
      else if (rd_istat) flow_evt <= 1'b0;
      if (rx_done) begin
        prev_on1 <= m_on1;
        prev_off1 <= m_off1;
      end
      if (xoff_hit) xoff_flag <= 1'b1;
      else if (xon_hit) xoff_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_above_q <= 1'b0;
      xdly_run <= 1'b0;
      xdly_cnt <= 9'h000;
      xoff_sent <= 1'b0;
      flow_left <= 2'h0;
      flow_off <= 1'b0;
      tmo_cnt <= 10'h000;
    end else begin
      rx_above_q <= rx_above;
      if (!sw_tx_en) xdly_run <= 1'b0;
      else if (rx_above && !rx_above_q && !xoff_sent) begin
        xdly_run <= 1'b1;
        xdly_cnt <= 9'h000;
      end else if (xoff_fire) xdly_run <= 1'b0;
      else if (xdly_run && tick) xdly_cnt <= xdly_cnt + 9'h001;
      if (xoff_fire) xoff_sent <= 1'b1;
      else if (xon_fire || !sw_tx_en) xoff_sent <= 1'b0;
      if (xoff_fire || xon_fire) begin
        flow_left <= flow_n;
        flow_off <= xoff_fire;
      end else if (tx_start_flow) flow_left <= flow_left - 2'h1;
      if (rx_done || rx_pop || !rx_ready) tmo_cnt <= 10'h000;
      else if (tick && !tmo_hit) tmo_cnt <= tmo_cnt + 10'h001;
    end
  end

  // status and interrupt
  wire rx_cond = extra_feature[XF_RX_TRIG_INT] ? rx_above : rx_ready;
  wire ip_rx = int_enable[IE_RX] && rx_cond;
  wire ip_tmo = int_enable[IE_RX] && tmo_hit;
  wire ip_tx = int_enable[IE_TX] && tx_count < tx_trig;
  wire ip_xoff = int_enable[IE_XOFF] && xoff_flag;
  wire ip_any = ip_rx || ip_tmo || ip_tx || ip_xoff || flow_evt;
  wire [2:0] head_tags = rx_ready ? {rx_head.brk, rx_head.frm, rx_head.perr}
                                  : 3'b000;
  wire [7:0] line_status = {1'b0, tx_empty, thr_empty, head_tags,
                            1'b0, rx_ready};
  wire [7:0] int_status = {2'b00, flow_evt, xoff_flag, ip_tmo, ip_rx,
                           ip_tx, !ip_any};
  wire [7:0] rx_data_rd = rx_ready ? rx_head.data : 8'h00;
  wire [7:0] rd_word =
    (addr_i == A_DATA) ? rx_data_rd :
    (addr_i == A_INT_EN) ? int_enable :
    (addr_i == A_INT_STAT) ? int_status :
    (addr_i == A_LINE_CTL) ? line_control :
    (addr_i == A_MODEM_CTL) ? modem_control :
    (addr_i == A_LINE_STAT) ? line_status :
    (addr_i == A_ENH_FEAT) ? enhanced_feature :
    (addr_i == A_EXTRA_FEAT) ? extra_feature :
    xchr_sel ? flow_chr[addr_i[1:0]] :
    (addr_i == A_DIV_LO) ? divisor[7:0] :
    (addr_i == A_DIV_HI) ? divisor[15:8] : 8'h00;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
      int_o <= 1'b0;
    end else begin
      rdata_o <= rd_i ? rd_word : 8'h00;
      int_o <= ip_any;
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_thr_empty_flag: assert property (
    rd_i && addr_i == A_LINE_STAT |=>
      rdata_o[LS_THR_EMPTY] == ($past(tx_count) == '0))
    else $error("thr empty flag wrong");
  a_tx_empty_flag: assert property (
    rd_i && addr_i == A_LINE_STAT |=> rdata_o[LS_TX_EMPTY] ==
      ($past(tx_count) == '0 && $past(tx_state) == TX_IDLE))
    else $error("tx empty flag wrong");
  a_tx_int_level: assert property (
    int_enable[IE_TX] && tx_count < tx_trig |=> int_o)
    else $error("tx level interrupt missing");
  a_start_reject: assert property (
    rx_state == RX_START && tick && rx_tcnt == MID_LAST && rx_i |=>
      rx_state == RX_IDLE)
    else $error("false start accepted");
  a_rx_tag_show: assert property (
    rd_i && addr_i == A_LINE_STAT && rx_ready |=>
      rdata_o[4:2] == $past({rx_head.brk, rx_head.frm, rx_head.perr}))
    else $error("head tags not shown");
  a_rx_pop_next: assert property (
    rd_data && rx_count > CNT_ONE && !rx_push |=>
      rx_rd_ptr == $past(rx_rd_ptr) + PTR_ONE &&
      rx_count == $past(rx_count) - CNT_ONE)
    else $error("rx read did not pop");
  a_rts_release: assert property (
    auto_rts && rx_count >= rts_hi |=> rts_n_o)
    else $error("rts not released");
  a_rts_restore: assert property (
    auto_rts && rx_count <= rts_lo |=> !rts_n_o ##1 rts_hold == 1'b0 ||
      rx_count > rts_lo)
    else $error("rts not restored");
  a_cts_halt: assert property (
    cts_halt && tx_idle |=> tx_state == TX_IDLE)
    else $error("tx started under cts halt");
  a_xoff_halt: assert property (
    xoff_halt && flow_left == 2'h0 && tx_idle |=> tx_state == TX_IDLE)
    else $error("tx started after xoff");
  a_flow_chr_reset: assert property (disable iff (1'b0)
    !reset_n_i |=> flow_chr[0] == 8'h00 && flow_chr[1] == 8'h00 &&
      flow_chr[2] == 8'h00 && flow_chr[3] == 8'h00)
    else $error("flow characters not cleared");
  a_flow_not_stored: assert property (
    rx_done && flow_match && !rx_pop |=> rx_count == $past(rx_count))
    else $error("flow character stored");
  a_tmo_int: assert property (
    int_enable[IE_RX] && tmo_hit |=> int_o)
    else $error("timeout interrupt missing");
endmodule
`default_nettype wire
